// File: hw/gpabc_ports.v
// GPIO ports A, B and C with port B pull-ups and change detection, APB register access
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "gpabc_regs.vh"

// Summary of operation
// R1 - Port A pin four drives low only
// R2 - Port A pin four feeds Timer0 clock
// R3 - Port A pin five is slave select
// R4 - Port A upper bits zero; direction resets 0x3F
// R5 - Port B direction one floats the pin
// R6 - Port B direction zero drives latch
// R7 - Cleared pullup_disable_bar enables port B pull-ups
// R8 - Output-configured pin loses its pull-up
// R9 - Reset sets pull-up config to all ones
// R10 - Only input change_pins join comparison
// R11 - Compare pins against value latched at read
// R12 - ORed mismatches set change_irq_flag
// R13 - Change interrupt wakes device from sleep
// R14 - Port B access re-latches comparison values
// R15 - Mismatch keeps flag set; read, then clear
// R16 - Older variant may miss change during read
// R17 - Port B pin zero is external interrupt
// R18 - Port B pins six, seven serve programming
// R19 - Port C eight pins, per-bit direction
// R20 - Peripheral overrides port C direction while enabled
// R21 - Software avoids RMW on overridden direction
// R22 - Software avoids polling port B
// R23 - Port read returns pins; write loads latch
// R24 - Port A direction floats or drives latch
// R25 - Flag stays set until software writes zero
module gpabc_ports #(
  parameter SMALL_VARIANT = 0,
  parameter OLD_VARIANT = 0
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`GPABC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Port A pins
  input wire [5:0] pa_in,
  output wire [5:0] pa_out,
  output wire [5:0] pa_oe,
  // Port B pins
  input wire [7:0] pb_in,
  output wire [7:0] pb_out,
  output wire [7:0] pb_oe,
  output wire [7:0] pb_pullup_en,
  // Port C pins
  input wire [7:0] pc_in,
  output wire [7:0] pc_out,
  output wire [7:0] pc_oe,
  // Port C peripheral overrides
  input wire [7:0] pc_periph_force_out,
  input wire [7:0] pc_periph_force_in,
  input wire [7:0] pc_periph_data,
  // Peripheral taps
  output wire timer0_ext_clk,
  output wire ssp_slave_sel,
  output wire ext_irq_in,
  output wire [6:0] timer_cfg,
  // Serial programming
  input wire prog_mode,
  input wire prog_data_out,
  input wire prog_data_oe,
  output wire prog_clk,
  output wire prog_data_in,
  // Change interrupt and wake
  output wire change_irq,
  output wire wake_req
);

  // ==================================================
  // Pin synchronisers
  reg [5:0] pa_meta_r;
  reg [5:0] pa_sync_r;
  reg [7:0] pb_meta_r;
  reg [7:0] pb_sync_r;
  reg [7:0] pc_meta_r;
  reg [7:0] pc_sync_r;
  // Programming-mode entry comes from outside as well, so it is synchronised
  reg prog_meta_r;
  reg prog_sync_r;

  // Only the second flop of each pair feeds logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_meta_r <= 6'h00;
      pa_sync_r <= 6'h00;
      pb_meta_r <= 8'h00;
      pb_sync_r <= 8'h00;
      pc_meta_r <= 8'h00;
      pc_sync_r <= 8'h00;
      prog_meta_r <= 1'b0;
      prog_sync_r <= 1'b0;
    end else begin
      pa_meta_r <= pa_in;
      pa_sync_r <= pa_meta_r;
      pb_meta_r <= pb_in;
      pb_sync_r <= pb_meta_r;
      pc_meta_r <= pc_in;
      pc_sync_r <= pc_meta_r;
      prog_meta_r <= prog_mode;
      prog_sync_r <= prog_meta_r;
    end
  end

  // ==================================================
  // Registers
  reg [5:0] port_a_latch_r;
  reg [7:0] port_b_latch_r;
  reg [7:0] port_c_latch_r;
  reg [5:0] port_a_direction_r;
  reg [7:0] port_b_direction_r;
  reg [7:0] port_c_direction_r;
  reg [7:0] timer_pullup_config_r;
  reg change_irq_flag_r;
  reg change_irq_enable_r;
  reg [3:0] change_latch_r;
  reg [7:0] pb_read_snap_r;
  reg [31:0] prdata_r;
  reg pslverr_r;

  wire [7:0] index = paddr[9:2];
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_en = access_ph & pwrite & pstrb[0];
  wire [7:0] wd = pwdata[7:0];
  wire hit_a = (index == `GPABC_IDX_PORT_A_PINS);
  wire hit_b = (index == `GPABC_IDX_PORT_B_PINS);
  wire hit_c = (index == `GPABC_IDX_PORT_C_PINS);
  wire hit_irq = (index == `GPABC_IDX_IRQ_CONTROL);
  wire hit_cfg = (index == `GPABC_IDX_TIMER_PULLUP_CFG);
  wire hit_dira = (index == `GPABC_IDX_PORT_A_DIR);
  wire hit_dirb = (index == `GPABC_IDX_PORT_B_DIR);
  wire hit_dirc = (index == `GPABC_IDX_PORT_C_DIR);
  wire mapped = hit_a | hit_b | hit_c | hit_irq | hit_cfg | hit_dira | hit_dirb | hit_dirc;
  // Byte offset and upper address bits must be zero
  wire aligned = (paddr[1:0] == 2'b00) & (paddr[`GPABC_ADDR_W-1:10] == 2'b00);
  wire legal = mapped & aligned;

  // Port A bit five absent on the small variant
  wire [5:0] pa_mask = (SMALL_VARIANT != 0) ? 6'h1F : 6'h3F;
  wire [5:0] pa_dir_eff = port_a_direction_r & pa_mask;
  wire [5:0] pa_pins_rd = pa_sync_r & pa_mask; // [R3]

  // Port C effective direction under peripheral override
  // A forced input wins over a forced output
  wire [7:0] pc_dir_eff = (port_c_direction_r & ~pc_periph_force_out) | pc_periph_force_in; // [R20]

  // ==================================================
  // Read data, captured in the setup cycle
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (index)
      `GPABC_IDX_PORT_A_PINS: begin
        rd_byte = {2'b00, pa_pins_rd}; // [R4] [R23]
      end
      `GPABC_IDX_PORT_B_PINS: begin
        rd_byte = pb_sync_r; // [R23]
      end
      `GPABC_IDX_PORT_C_PINS: begin
        rd_byte = pc_sync_r; // [R23]
      end
      `GPABC_IDX_IRQ_CONTROL: begin
        rd_byte = {4'h0, change_irq_enable_r, 2'b00, change_irq_flag_r};
      end
      `GPABC_IDX_TIMER_PULLUP_CFG: begin
        rd_byte = timer_pullup_config_r;
      end
      `GPABC_IDX_PORT_A_DIR: begin
        rd_byte = {2'b00, pa_dir_eff}; // [R4]
      end
      `GPABC_IDX_PORT_B_DIR: begin
        rd_byte = port_b_direction_r;
      end
      `GPABC_IDX_PORT_C_DIR: begin
        rd_byte = port_c_direction_r;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // The port B snapshot lets a read re-latch exactly the value it returned
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      pb_read_snap_r <= 8'h00;
    end else if (setup_ph) begin
      prdata_r <= (pwrite | ~legal) ? 32'h00000000 : {24'h000000, rd_byte};
      pslverr_r <= ~legal;
      pb_read_snap_r <= pb_sync_r;
    end
  end

  assign prdata = prdata_r;
  // Zero wait states: every access phase completes at once
  assign pready = access_ph;
  assign pslverr = access_ph & pslverr_r;

  // ==================================================
  // Latches, direction and configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_latch_r <= `GPABC_RST_PORT_A_LATCH;
      port_b_latch_r <= `GPABC_RST_LATCH;
      port_c_latch_r <= `GPABC_RST_LATCH;
      port_a_direction_r <= `GPABC_RST_PORT_A_DIR; // [R4]
      port_b_direction_r <= `GPABC_RST_PORT_B_DIR;
      port_c_direction_r <= `GPABC_RST_PORT_C_DIR;
      timer_pullup_config_r <= `GPABC_RST_TIMER_PULLUP_CFG; // [R9]
      change_irq_enable_r <= `GPABC_RST_IRQ_ENABLE;
    end else if (wr_en & legal) begin
      if (hit_a) begin
        port_a_latch_r <= wd[5:0] & pa_mask; // [R23]
      end
      if (hit_b) begin
        port_b_latch_r <= wd; // [R23]
      end
      if (hit_c) begin
        port_c_latch_r <= wd; // [R23]
      end
      if (hit_dira) begin
        port_a_direction_r <= wd[5:0] & pa_mask; // [R3]
      end
      if (hit_dirb) begin
        port_b_direction_r <= wd;
      end
      if (hit_dirc) begin
        port_c_direction_r <= wd; // [R19]
      end
      if (hit_cfg) begin
        timer_pullup_config_r <= wd;
      end
      if (hit_irq) begin
        change_irq_enable_r <= wd[`GPABC_CHANGE_IRQ_ENABLE_BIT];
      end
    end
  end

  // ==================================================
  // Port B change detection
  // Any port B access, read or write, re-latches the compared value
  wire pb_access = access_ph & legal & hit_b;
  wire [3:0] change_pins = pb_sync_r[`GPABC_CHANGE_HI:`GPABC_CHANGE_LO];
  wire [3:0] change_inputs = port_b_direction_r[`GPABC_CHANGE_HI:`GPABC_CHANGE_LO]; // [R10]
  wire [3:0] mismatch = (change_pins ^ change_latch_r) & change_inputs; // [R10] [R11]
  wire mismatch_any = |mismatch; // [R12]
  // Software clears the flag by writing zero to its bit
  wire flag_clr = wr_en & legal & hit_irq & ~wd[`GPABC_CHANGE_IRQ_FLAG_BIT];
  wire flag_wset = wr_en & legal & hit_irq & wd[`GPABC_CHANGE_IRQ_FLAG_BIT];
  // Newer parts keep the value seen by the read so a coincident change still mismatches
  wire [3:0] relatch_val = ((OLD_VARIANT != 0) || pwrite) ? change_pins :
    pb_read_snap_r[`GPABC_CHANGE_HI:`GPABC_CHANGE_LO]; // [R16]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_latch_r <= 4'h0;
      change_irq_flag_r <= 1'b0;
    end else begin
      if (pb_access) begin
        change_latch_r <= relatch_val; // [R14] [R11]
      end
      // Hardware set wins over a software clear
      if (mismatch_any | flag_wset) begin
        change_irq_flag_r <= 1'b1; // [R12] [R15] [R25]
      end else if (flag_clr) begin
        change_irq_flag_r <= 1'b0; // [R25]
      end
    end
  end

  assign change_irq = change_irq_flag_r & change_irq_enable_r;
  // Wake also follows the live mismatch, one cycle ahead of the flag
  assign wake_req = change_irq_enable_r & (change_irq_flag_r | mismatch_any); // [R13]

  // ==================================================
  // Pin drivers, registered
  reg [5:0] pa_out_r;
  reg [5:0] pa_oe_r;
  reg [7:0] pb_out_r;
  reg [7:0] pb_oe_r;
  reg [7:0] pb_pullup_r;
  reg [7:0] pc_out_r;
  reg [7:0] pc_oe_r;
  reg [5:0] pa_out_nxt;
  reg [5:0] pa_oe_nxt;
  reg [7:0] pb_out_nxt;
  reg [7:0] pb_oe_nxt;
  reg [7:0] pc_out_nxt;

  always @* begin
    pa_out_nxt = port_a_latch_r & pa_mask;
    pa_oe_nxt = ~pa_dir_eff & pa_mask; // [R24]
    // Open drain: only ever pulls low
    pa_out_nxt[`GPABC_PA_OPEN_DRAIN_BIT] = 1'b0; // [R1]
    pa_oe_nxt[`GPABC_PA_OPEN_DRAIN_BIT] = ~port_a_direction_r[`GPABC_PA_OPEN_DRAIN_BIT] &
      ~port_a_latch_r[`GPABC_PA_OPEN_DRAIN_BIT]; // [R1]
    pb_out_nxt = port_b_latch_r; // [R6]
    pb_oe_nxt = ~port_b_direction_r; // [R5] [R6]
    if (prog_sync_r) begin
      pb_oe_nxt[`GPABC_PB_PROG_CLK_BIT] = 1'b0; // [R18]
      pb_out_nxt[`GPABC_PB_PROG_DATA_BIT] = prog_data_out; // [R18]
      pb_oe_nxt[`GPABC_PB_PROG_DATA_BIT] = prog_data_oe; // [R18]
    end
    pc_out_nxt = (port_c_latch_r & ~pc_periph_force_out) | (pc_periph_data & pc_periph_force_out); // [R20]
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out_r <= 6'h00;
      pa_oe_r <= 6'h00;
      pb_out_r <= 8'h00;
      pb_oe_r <= 8'h00;
      pb_pullup_r <= 8'h00;
      pc_out_r <= 8'h00;
      pc_oe_r <= 8'h00;
    end else begin
      pa_out_r <= pa_out_nxt;
      pa_oe_r <= pa_oe_nxt;
      pb_out_r <= pb_out_nxt;
      pb_oe_r <= pb_oe_nxt;
      // Pull-ups follow the actual drive, so a driven pin never has one
      pb_pullup_r <= {8{~timer_pullup_config_r[`GPABC_PULLUP_DISABLE_BAR_BIT]}} & ~pb_oe_nxt; // [R7] [R8]
      pc_out_r <= pc_out_nxt;
      pc_oe_r <= ~pc_dir_eff; // [R19] [R20]
    end
  end

  assign pa_out = pa_out_r;
  assign pa_oe = pa_oe_r;
  assign pb_out = pb_out_r;
  assign pb_oe = pb_oe_r;
  assign pb_pullup_en = pb_pullup_r;
  assign pc_out = pc_out_r;
  assign pc_oe = pc_oe_r;

  // ==================================================
  // Programming taps, registered so they leave from flops
  reg prog_clk_r;
  reg prog_data_in_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_clk_r <= 1'b0;
      prog_data_in_r <= 1'b0;
    end else begin
      // Gated so pin activity outside programming mode reads as idle
      prog_clk_r <= prog_sync_r & pb_sync_r[`GPABC_PB_PROG_CLK_BIT]; // [R18]
      prog_data_in_r <= prog_sync_r & pb_sync_r[`GPABC_PB_PROG_DATA_BIT]; // [R18]
    end
  end

  // ==================================================
  // Peripheral taps of shared pins
  assign timer0_ext_clk = pa_sync_r[`GPABC_PA_OPEN_DRAIN_BIT]; // [R2]
  assign ssp_slave_sel = pa_pins_rd[`GPABC_PA_SLAVE_SEL_BIT]; // [R3]
  assign ext_irq_in = pb_sync_r[`GPABC_PB_EXT_IRQ_BIT]; // [R17]
  assign prog_clk = prog_clk_r; // [R18]
  assign prog_data_in = prog_data_in_r; // [R18]
  assign timer_cfg = timer_pullup_config_r[6:0];

endmodule

// File: hw/gpabc_regs.vh
// Register indices, field positions, reset values and widths of the GPIO port block
`ifndef GPABC_REGS_VH
`define GPABC_REGS_VH

// ==================================================
// Register indices (byte address is four times the index)
`define GPABC_IDX_PORT_A_PINS 8'h05
`define GPABC_IDX_PORT_B_PINS 8'h06
`define GPABC_IDX_PORT_C_PINS 8'h07
`define GPABC_IDX_IRQ_CONTROL 8'h0B
`define GPABC_IDX_TIMER_PULLUP_CFG 8'h81
`define GPABC_IDX_PORT_A_DIR 8'h85
`define GPABC_IDX_PORT_B_DIR 8'h86
`define GPABC_IDX_PORT_C_DIR 8'h87
`define GPABC_ADDR_W 12

// ==================================================
// Reset values
`define GPABC_RST_PORT_A_DIR 6'h3F
`define GPABC_RST_PORT_B_DIR 8'hFF
`define GPABC_RST_PORT_C_DIR 8'hFF
`define GPABC_RST_TIMER_PULLUP_CFG 8'hFF
`define GPABC_RST_LATCH 8'h00
`define GPABC_RST_PORT_A_LATCH 6'h00
`define GPABC_RST_IRQ_ENABLE 1'b0

// ==================================================
// Field positions
`define GPABC_PA_WIDTH 6
`define GPABC_PA_OPEN_DRAIN_BIT 4
`define GPABC_PA_SLAVE_SEL_BIT 5
`define GPABC_PB_EXT_IRQ_BIT 0
`define GPABC_PB_PROG_CLK_BIT 6
`define GPABC_PB_PROG_DATA_BIT 7
`define GPABC_CHANGE_LO 4
`define GPABC_CHANGE_HI 7
`define GPABC_PULLUP_DISABLE_BAR_BIT 7
`define GPABC_CHANGE_IRQ_FLAG_BIT 0
`define GPABC_CHANGE_IRQ_ENABLE_BIT 3

`endif

// File: test/gpabc_pins.sv
// Pin-side model: keypad and circuitry on ports A, B and C
`timescale 1ns/10ps
module gpabc_pins (
  // Clock
  input wire pclk,
  // Device drive
  input wire [5:0] pa_out,
  input wire [5:0] pa_oe,
  input wire [7:0] pb_out,
  input wire [7:0] pb_oe,
  input wire [7:0] pb_pullup_en,
  input wire [7:0] pc_out,
  input wire [7:0] pc_oe,
  // External drive
  input wire [5:0] pa_ext,
  input wire [7:0] pb_ext,
  input wire [7:0] pb_ext_en,
  input wire [7:0] pc_ext,
  // Pin levels
  output logic [5:0] pa_in,
  output logic [7:0] pb_in,
  output logic [7:0] pc_in
);
  logic [7:0] flt_r = 8'h55;
  // Undriven pin without pull-up wanders
  always @(posedge pclk) flt_r <= ~flt_r;
  always @* begin
    pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    pa_in[4] = pa_oe[4] ? 1'b0 : pa_ext[4];
    pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext_en & pb_ext)
      | (~pb_oe & ~pb_ext_en & (pb_pullup_en | flt_r));
    pc_in = (pc_oe & pc_out) | (~pc_oe & pc_ext);
  end
endmodule

// File: test/gpabc_ports_checker.sv
// Port-level assertions for the GPIO port block
`timescale 1ns/10ps
module gpabc_ports_checker (
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Pins and taps
  input wire [5:0] pa_in,
  input wire [5:0] pa_out,
  input wire [7:0] pb_in,
  input wire [7:0] pb_oe,
  input wire [7:0] pb_pullup_en,
  input wire [7:0] pc_oe,
  input wire [7:0] pc_periph_force_out,
  input wire [7:0] pc_periph_force_in,
  input wire timer0_ext_clk,
  input wire ext_irq_in,
  input wire change_irq,
  input wire wake_req
);
  wire [7:0] fo = pc_periph_force_out & ~pc_periph_force_in;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence run_two;
    presetn && $past(presetn) && $past(presetn, 2);
  endsequence
  sequence setup_then_access;
    (psel && !penable) ##1 (psel && penable);
  endsequence
  drain_only_a: assert property (pa_out[4] == 1'b0)
    else $error("pin a4 driven high");
  tmr_clk_a: assert property (run_two |-> timer0_ext_clk == $past(pa_in[4], 2))
    else $error("timer clock tap wrong");
  ext_irq_a: assert property (run_two |-> ext_irq_in == $past(pb_in[0], 2))
    else $error("external irq tap wrong");
  pullup_off_a: assert property ((pb_pullup_en & pb_oe) == 8'h00)
    else $error("pull-up on driven pin");
  por_pullup_a: assert property ($rose(presetn) |-> (pb_pullup_en == 8'h00)[*2])
    else $error("pull-up on after reset");
  force_in_a: assert property (|pc_periph_force_in |=> (pc_oe & $past(pc_periph_force_in)) == 8'h00)
    else $error("forced input still driven");
  force_out_a: assert property (|fo |=> (pc_oe & $past(fo)) == $past(fo))
    else $error("forced output not driven");
  irq_wake_a: assert property (change_irq |-> wake_req)
    else $error("irq without wake");
  zero_wait_a: assert property (setup_then_access |-> pready && !$past(pready))
    else $error("access not answered");
  slverr_a: assert property (pslverr |-> pready)
    else $error("error outside access");
endmodule
bind gpabc_ports gpabc_ports_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out),
  .pb_in(pb_in), .pb_oe(pb_oe), .pb_pullup_en(pb_pullup_en), .pc_oe(pc_oe),
  .pc_periph_force_out(pc_periph_force_out), .pc_periph_force_in(pc_periph_force_in),
  .timer0_ext_clk(timer0_ext_clk), .ext_irq_in(ext_irq_in), .change_irq(change_irq), .wake_req(wake_req));

// File: test/gpio_ports_abc_change_irq_tb.sv
// Self-checking bench for the GPIO port block
`timescale 1ns/10ps
`include "gpabc_regs.vh"
module gpio_ports_abc_change_irq_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] pa_in, pa_out, pa_oe, pa_ext;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pullup_en, pb_ext, pb_ext_en, pc_in, pc_out, pc_oe, pc_ext;
  logic [7:0] pc_periph_force_out, pc_periph_force_in, pc_periph_data, rd_v;
  logic prog_mode, prog_data_out, prog_data_oe, change_irq, wake_req, ssp_slave_sel, prog_clk, prog_data_in;
  logic [6:0] timer_cfg;
  int bad_count = 0;
  int n_compared = 0;
  gpabc_ports dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pullup_en(pb_pullup_en), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .pc_periph_force_out(pc_periph_force_out), .pc_periph_force_in(pc_periph_force_in),
    .pc_periph_data(pc_periph_data), .timer0_ext_clk(), .ssp_slave_sel(ssp_slave_sel), .ext_irq_in(),
    .timer_cfg(timer_cfg), .prog_mode(prog_mode), .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
    .prog_clk(prog_clk), .prog_data_in(prog_data_in), .change_irq(change_irq), .wake_req(wake_req));
  gpabc_pins pins (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pullup_en(pb_pullup_en), .pc_out(pc_out), .pc_oe(pc_oe), .pa_ext(pa_ext), .pb_ext(pb_ext),
    .pb_ext_en(pb_ext_en), .pc_ext(pc_ext), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));
  // ==================================================
  // Bus and compare helpers
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata[7:0];
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd_v, exp);
  endtask
  task settle;
    repeat (4) @(posedge pclk);
  endtask
  task conclude;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==================================================
  // Scenarios
  task t_reset;
    rd(`GPABC_IDX_PORT_A_DIR, 8'h3F);
    rd(`GPABC_IDX_PORT_B_DIR, 8'hFF);
    rd(`GPABC_IDX_TIMER_PULLUP_CFG, 8'hFF);
    chk(pb_pullup_en, 8'h00);
    rd(8'h40, 8'h00);
    chk({7'h00, err_v}, 8'h01);
  endtask
  task t_port_a_pin_data;
    apb(1'b1, `GPABC_IDX_PORT_A_PINS, 8'h1F);
    apb(1'b1, `GPABC_IDX_PORT_A_DIR, 8'h00);
    settle;
    chk({2'b00, pa_out}, 8'h0F);
    chk({2'b00, pa_oe}, 8'h2F);
    apb(1'b1, `GPABC_IDX_PORT_A_DIR, 8'hFF);
    settle;
    rd(`GPABC_IDX_PORT_A_PINS, 8'h2A);
    chk({7'h00, ssp_slave_sel}, 8'h01);
    pa_ext <= 6'h1A;
    settle;
    rd(`GPABC_IDX_PORT_A_PINS, 8'h1A);
    chk({7'h00, ssp_slave_sel}, 8'h00);
  endtask
  task t_port_b_pin_data;
    apb(1'b1, `GPABC_IDX_PORT_B_PINS, 8'hA5);
    apb(1'b1, `GPABC_IDX_PORT_B_DIR, 8'hF0);
    apb(1'b1, `GPABC_IDX_TIMER_PULLUP_CFG, 8'h7F);
    settle;
    chk(pb_oe, 8'h0F);
    chk(pb_out & 8'h0F, 8'h05);
    chk(pb_pullup_en, 8'hF0);
    rd(`GPABC_IDX_PORT_B_PINS, 8'hF5);
    chk({1'b0, timer_cfg}, 8'h7F);
  endtask
  task t_change;
    pb_ext_en <= 8'hF0;
    apb(1'b1, `GPABC_IDX_IRQ_CONTROL, 8'h08);
    rd(`GPABC_IDX_PORT_B_PINS, 8'hF5);
    pb_ext <= 8'h70;
    settle;
    // No polling of port B while waiting for the change
    chk({6'h00, change_irq, wake_req}, 8'h03);
    rd(`GPABC_IDX_IRQ_CONTROL, 8'h09);
    apb(1'b1, `GPABC_IDX_IRQ_CONTROL, 8'h08);
    settle;
    chk({7'h00, change_irq}, 8'h01);
    rd(`GPABC_IDX_PORT_B_PINS, 8'h75);
    apb(1'b1, `GPABC_IDX_IRQ_CONTROL, 8'h08);
    apb(1'b1, `GPABC_IDX_PORT_B_DIR, 8'h70);
    settle;
    chk({7'h00, change_irq}, 8'h00);
    apb(1'b1, `GPABC_IDX_PORT_B_DIR, 8'hF0);
    pb_ext <= 8'hF0;
    settle;
    chk({7'h00, change_irq}, 8'h01);
    apb(1'b1, `GPABC_IDX_PORT_B_PINS, 8'hA5);
    apb(1'b1, `GPABC_IDX_IRQ_CONTROL, 8'h08);
    settle;
    chk({7'h00, change_irq}, 8'h00);
  endtask
  task t_prog;
    {prog_mode, prog_data_out, prog_data_oe} <= 3'b111;
    settle;
    settle;
    chk(pb_oe & 8'hC0, 8'h80);
    chk({6'h00, prog_clk, prog_data_in}, 8'h03);
    prog_data_out <= 1'b0;
    settle;
    settle;
    chk({6'h00, prog_clk, prog_data_in}, 8'h02);
    prog_mode <= 1'b0;
    settle;
    settle;
    chk({6'h00, prog_clk, prog_data_in}, 8'h00);
  endtask
  task t_port_c_pins;
    apb(1'b1, `GPABC_IDX_PORT_C_DIR, 8'h00);
    apb(1'b1, `GPABC_IDX_PORT_C_PINS, 8'h3C);
    pc_periph_force_in <= 8'h01;
    settle;
    chk(pc_out, 8'h3C);
    chk(pc_oe, 8'hFE);
    // Whole-register write, no read-modify-write under override
    apb(1'b1, `GPABC_IDX_PORT_C_DIR, 8'hFF);
    pc_periph_force_out <= 8'h02;
    pc_periph_data <= 8'h02;
    settle;
    chk(pc_oe, 8'h02);
    chk(pc_out & 8'h02, 8'h02);
  endtask
  // ==================================================
  // Clock, reset, sequence and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, prog_mode, prog_data_out, prog_data_oe} <= 7'h00;
    {paddr, pwdata, pstrb} <= {12'h000, 32'h00000000, 4'hF};
    {pa_ext, pb_ext, pb_ext_en, pc_ext} <= {6'h2A, 8'hF0, 8'h00, 8'h5A};
    {pc_periph_force_out, pc_periph_force_in, pc_periph_data} <= 24'h000000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_port_a_pin_data;
    t_port_b_pin_data;
    t_change;
    t_prog;
    t_port_c_pins;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    conclude;
  end
endmodule
